// *** include/loopback_test_control_consts.svh ***
`ifndef LOOPBACK_TEST_CONTROL_CONSTS_SVH
`define LOOPBACK_TEST_CONTROL_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CLK_HZ 100000000
`define DEBOUNCE_MS 10
`define LAMP_CHECK_MS 200
`define BLINK_MS 125

// ----------------------------------------------------------------------------
// Pattern checker
// ----------------------------------------------------------------------------
`define PRBS_SEED 9'h1ff
`define PRBS_TAP_HI 8
`define PRBS_TAP_LO 4
`define ERR_WINDOW_BITS 7'h40
`define ERR_CONT_THRESH 7'h30

// ----------------------------------------------------------------------------
// Line levels
// ----------------------------------------------------------------------------
`define LINE_MARK 1'h1
`define LINE_SPACE 1'h0

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_ERRCOUNT 8'h08
`define CONTROL_RESET 2'h1
`define CTRL_DTE_ALLOW 0
`define CTRL_CLEAR_COUNT 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** include/loopback_test_control_pkg.sv ***
package loopback_test_control_pkg;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic local_outbound_loop_button;
    logic local_line_loop_button;
    logic far_unit_loop_button;
    logic prbs_test_button;
    logic dte_local_loop_enable_jumper;
    logic dte_remote_loop_enable_strap;
    logic carrier_forced_on_jumper;
  } panel_in_t;

  typedef struct packed {
    logic rts_led;
    logic transmit_activity_led;
    logic receive_activity_led;
    logic carrier_detect_led;
    logic test_led;
    logic bit_fault_lamp;
  } lamps_t;

  typedef enum logic [1:0] {
    FAULT_NONE,
    FAULT_INTERMITTENT,
    FAULT_CONTINUOUS
  } fault_t;

  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [8:0] sample;
    logic [8:0] stable;
    logic [31:0] deb_cnt;
    logic outbound_mode;
    logic line_mode;
    logic far_mode;
    logic prbs_mode;
    logic [1:0] control;
    logic [8:0] gen;
    logic [8:0] chk;
    logic [6:0] win_bits;
    logic [6:0] win_errs;
    fault_t fault;
    logic [15:0] err_count;
    logic [31:0] lamp_cnt;
    logic [31:0] blink_cnt;
    logic blink_phase;
    logic fiber_tx_data;
    logic remote_loop_command;
    logic dte_rx_data;
    logic dte_cts;
    logic dte_dsr;
    lamps_t lamps;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    axi_rsp_t axi;
  } state_t;

endpackage

// *** core/loopback_test_control.sv ***
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "loopback_test_control_consts.svh"
// What this block does
// - Outbound loop button loops fiber receive data into fiber transmit; DSR goes low.
// - Line loop button feeds own transmitter output back into own receiver.
// - DTE may request line loop only while its enable jumper is set.
// - Far unit button commands partner modem into its loop; DSR goes low.
// - DTE may request remote loop only while its enable strap is set.
// - Pattern test sends the 511-bit sequence and checks what comes back.
// - Fault lamp steady for continuous errors, blinking for intermittent ones.
// - During pattern test, receive data and clear to send are held low.
// - Fault lamp lights briefly when pattern test starts, then only on errors.
// - Request to send lamp follows the terminal's request to send.
// - Transmit lamp on for steady space, flickers with changing data.
// - Receive lamp on for steady space, flickers with changing data.
// - Carrier lamp lit while a valid optical signal is received; during line loop it shows the carrier forced-on jumper or RTS.
// - Test lamp lit whenever any loop mode is active, from panel or DTE.
// - Block runs by itself after reset, with no start command needed.
// - During line loop the fiber transmitter sends steady mark.
// - During pattern test the DTE is disconnected from the data path.
module loopback_test_control #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_MS * (`CLK_HZ / 1000),
  parameter int LAMP_CHECK_CYCLES = `LAMP_CHECK_MS * (`CLK_HZ / 1000),
  parameter int BLINK_CYCLES = `BLINK_MS * (`CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register bus
  input wire loopback_test_control_pkg::axi_req_t axi_req,
  output loopback_test_control_pkg::axi_rsp_t axi_rsp,
  // Front panel and straps, asynchronous
  input wire loopback_test_control_pkg::panel_in_t panel,
  // DTE control leads, asynchronous
  input wire logic dte_rts,
  input wire logic dte_local_loop_req,
  input wire logic dte_remote_loop_req,
  // Line data, on sys_clk with a one-cycle bit strobe
  input wire logic bit_tick,
  input wire logic dte_tx_data,
  input wire logic fiber_rx_data,
  // Optical receive level detector, asynchronous
  input wire logic fiber_signal_valid,
  // Line and DTE outputs
  output logic fiber_tx_data,
  output logic remote_loop_command,
  output logic dte_rx_data,
  output logic dte_cts,
  output logic dte_dsr,
  // Panel lamps
  output loopback_test_control_pkg::lamps_t lamps
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  loopback_test_control_pkg::state_t cur;
  loopback_test_control_pkg::state_t next_cur;

  logic [10:0] raw_in;
  assign raw_in = {fiber_signal_valid, dte_rts, panel.carrier_forced_on_jumper,
                   panel.dte_remote_loop_enable_strap, panel.dte_local_loop_enable_jumper,
                   dte_remote_loop_req, dte_local_loop_req, panel.prbs_test_button,
                   panel.far_unit_loop_button, panel.local_line_loop_button,
                   panel.local_outbound_loop_button};

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic [8:0] agree;
    logic [8:0] rise;
    logic dte_ll;
    logic dte_rl;
    logic line_loop;
    logic remote_loop;
    logic carrier_ok;
    logic gen_bit;
    logic src_bit;
    logic rx_bit;
    logic expected;
    logic bit_err;
    logic prbs_start;
    logic [31:0] rdata;
    logic rd_ok;
    logic wr_ok;
    agree = '0;
    rise = '0;
    dte_ll = 1'b0;
    dte_rl = 1'b0;
    line_loop = 1'b0;
    remote_loop = 1'b0;
    carrier_ok = 1'b0;
    gen_bit = 1'b0;
    src_bit = 1'b0;
    rx_bit = 1'b0;
    expected = 1'b0;
    bit_err = 1'b0;
    prbs_start = 1'b0;
    rdata = '0;
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    next_cur = cur;

    // Two-stage synchroniser; only the second stage feeds logic.
    next_cur.sync1 = raw_in;
    next_cur.sync2 = cur.sync1;

    // A level counts once it has matched over two debounce samples.
    if (cur.deb_cnt >= 32'(DEBOUNCE_CYCLES - 1))
    begin
      next_cur.deb_cnt = '0;
      agree = ~(cur.sync2[8:0] ^ cur.sample);
      next_cur.stable = (cur.stable & ~agree) | (cur.sync2[8:0] & agree);
      next_cur.sample = cur.sync2[8:0];
    end
    else
    begin
      next_cur.deb_cnt = cur.deb_cnt + 32'h0000_0001;
    end
    rise = next_cur.stable & ~cur.stable;

    // Latching panel buttons: each press toggles its mode once.
    if (rise[0])
    begin
      next_cur.outbound_mode = ~cur.outbound_mode;
    end
    if (rise[1])
    begin
      next_cur.line_mode = ~cur.line_mode;
    end
    if (rise[2])
    begin
      next_cur.far_mode = ~cur.far_mode;
    end
    if (rise[3])
    begin
      next_cur.prbs_mode = ~cur.prbs_mode;
    end
    prbs_start = next_cur.prbs_mode & ~cur.prbs_mode;

    // DTE requests are level driven and gated by their straps.
    dte_ll = cur.stable[4] & cur.stable[6] & cur.control[`CTRL_DTE_ALLOW];
    dte_rl = cur.stable[5] & cur.stable[7] & cur.control[`CTRL_DTE_ALLOW];
    line_loop = cur.line_mode | dte_ll;
    remote_loop = cur.far_mode | dte_rl;
    carrier_ok = cur.stable[8] | cur.sync2[9];

    // Pattern generator and self-synchronising checker.
    gen_bit = cur.gen[`PRBS_TAP_HI] ^ cur.gen[`PRBS_TAP_LO];
    src_bit = (cur.prbs_mode && carrier_ok) ? gen_bit : dte_tx_data;
    if (cur.prbs_mode && !carrier_ok)
    begin
      src_bit = `LINE_MARK;
    end
    rx_bit = line_loop ? src_bit : fiber_rx_data;
    expected = cur.chk[`PRBS_TAP_HI] ^ cur.chk[`PRBS_TAP_LO];
    bit_err = rx_bit ^ expected;

    if (prbs_start)
    begin
      next_cur.lamp_cnt = 32'(LAMP_CHECK_CYCLES);
      next_cur.fault = loopback_test_control_pkg::FAULT_NONE;
      next_cur.win_bits = '0;
      next_cur.win_errs = '0;
    end
    else if (cur.lamp_cnt != 32'h0000_0000)
    begin
      next_cur.lamp_cnt = cur.lamp_cnt - 32'h0000_0001;
    end

    if (bit_tick)
    begin
      if (cur.prbs_mode)
      begin
        next_cur.gen = {cur.gen[7:0], gen_bit};
        next_cur.chk = {cur.chk[7:0], rx_bit};
        // Errors are ignored while the lamp check runs, which also covers checker lock.
        if (cur.lamp_cnt == 32'h0000_0000)
        begin
          next_cur.win_bits = cur.win_bits + 7'h01;
          next_cur.win_errs = cur.win_errs + {6'h00, bit_err};
          if (bit_err && cur.err_count != 16'hffff)
          begin
            next_cur.err_count = cur.err_count + 16'h0001;
          end
          if (cur.win_bits == `ERR_WINDOW_BITS - 7'h01)
          begin
            if (next_cur.win_errs >= `ERR_CONT_THRESH)
            begin
              next_cur.fault = loopback_test_control_pkg::FAULT_CONTINUOUS;
            end
            else if (next_cur.win_errs != 7'h00)
            begin
              next_cur.fault = loopback_test_control_pkg::FAULT_INTERMITTENT;
            end
            else
            begin
              next_cur.fault = loopback_test_control_pkg::FAULT_NONE;
            end
            // The window is judged on its full count before it restarts.
            next_cur.win_bits = '0;
            next_cur.win_errs = '0;
          end
        end
      end

      // Line side: steady mark during line loop, looped receive during outbound loop.
      if (line_loop)
      begin
        next_cur.fiber_tx_data = `LINE_MARK;
      end
      else if (cur.outbound_mode)
      begin
        next_cur.fiber_tx_data = fiber_rx_data;
      end
      else
      begin
        next_cur.fiber_tx_data = src_bit;
      end
      next_cur.dte_rx_data = cur.prbs_mode ? `LINE_SPACE : rx_bit;
      // A lamp that is lit on space stays on for steady space and flickers on data.
      next_cur.lamps.transmit_activity_led = (next_cur.fiber_tx_data == `LINE_SPACE);
      next_cur.lamps.receive_activity_led = (rx_bit == `LINE_SPACE);
    end

    if (cur.blink_cnt >= 32'(BLINK_CYCLES - 1))
    begin
      next_cur.blink_cnt = '0;
      next_cur.blink_phase = ~cur.blink_phase;
    end
    else
    begin
      next_cur.blink_cnt = cur.blink_cnt + 32'h0000_0001;
    end

    // DTE control leads and remaining lamps.
    next_cur.remote_loop_command = remote_loop;
    next_cur.dte_dsr = ~(cur.outbound_mode | remote_loop);
    next_cur.dte_cts = cur.prbs_mode ? 1'b0 : carrier_ok;
    next_cur.lamps.rts_led = cur.sync2[9];
    next_cur.lamps.carrier_detect_led = line_loop ? carrier_ok : cur.sync2[10];
    next_cur.lamps.test_led = cur.outbound_mode | line_loop | remote_loop;
    if (!cur.prbs_mode)
    begin
      next_cur.lamps.bit_fault_lamp = 1'b0;
    end
    else if (cur.lamp_cnt != 32'h0000_0000)
    begin
      next_cur.lamps.bit_fault_lamp = 1'b1;
    end
    else
    begin
      case (cur.fault)
        loopback_test_control_pkg::FAULT_CONTINUOUS: next_cur.lamps.bit_fault_lamp = 1'b1;
        loopback_test_control_pkg::FAULT_INTERMITTENT: next_cur.lamps.bit_fault_lamp = cur.blink_phase;
        default: next_cur.lamps.bit_fault_lamp = 1'b0;
      endcase
    end

    // AXI4-Lite write: address and data are taken in either order.
    if (axi_req.awvalid && cur.axi.awready)
    begin
      next_cur.aw_held = 1'b1;
      next_cur.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && cur.axi.wready)
    begin
      next_cur.w_held = 1'b1;
      next_cur.wdata = axi_req.wdata;
      next_cur.wstrb = axi_req.wstrb;
    end
    if (cur.axi.bvalid && axi_req.bready)
    begin
      next_cur.axi.bvalid = 1'b0;
    end
    if (cur.aw_held && cur.w_held && !cur.axi.bvalid)
    begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.axi.bvalid = 1'b1;
      wr_ok = (cur.awaddr == `REG_CONTROL) || (cur.awaddr == `REG_STATUS) ||
              (cur.awaddr == `REG_ERRCOUNT);
      next_cur.axi.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      if (cur.awaddr == `REG_CONTROL && cur.wstrb[0])
      begin
        next_cur.control[`CTRL_DTE_ALLOW] = cur.wdata[`CTRL_DTE_ALLOW];
        // Clearing loses no error: a new error in this cycle counts as one.
        if (cur.wdata[`CTRL_CLEAR_COUNT])
        begin
          next_cur.err_count = (bit_tick && cur.prbs_mode && cur.lamp_cnt == 32'h0000_0000)
                               ? {15'h0000, bit_err} : 16'h0000;
        end
      end
    end
    next_cur.axi.awready = ~next_cur.aw_held & ~next_cur.axi.bvalid;
    next_cur.axi.wready = ~next_cur.w_held & ~next_cur.axi.bvalid;

    // AXI4-Lite read: one outstanding read, answered the cycle after acceptance.
    if (cur.axi.rvalid && axi_req.rready)
    begin
      next_cur.axi.rvalid = 1'b0;
    end
    if (axi_req.arvalid && cur.axi.arready)
    begin
      rd_ok = 1'b1;
      case (axi_req.araddr)
        `REG_CONTROL: rdata = {30'h0000_0000, 1'b0, cur.control[`CTRL_DTE_ALLOW]};
        `REG_STATUS: rdata = {22'h00_0000, cur.fault, cur.lamps.bit_fault_lamp, carrier_ok,
                              cur.prbs_mode, remote_loop, line_loop, cur.outbound_mode,
                              dte_ll, dte_rl};
        `REG_ERRCOUNT: rdata = {16'h0000, cur.err_count};
        default: rd_ok = 1'b0;
      endcase
      next_cur.axi.rvalid = 1'b1;
      next_cur.axi.rdata = rdata;
      next_cur.axi.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    next_cur.axi.arready = ~next_cur.axi.rvalid;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Reset puts every mode off, so the modem passes data with no start command.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cur <= '0;
      cur.control <= `CONTROL_RESET;
      cur.gen <= `PRBS_SEED;
      cur.fiber_tx_data <= `LINE_MARK;
      cur.dte_rx_data <= `LINE_MARK;
      cur.dte_dsr <= 1'b1;
      cur.fault <= loopback_test_control_pkg::FAULT_NONE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign axi_rsp = cur.axi;
  assign fiber_tx_data = cur.fiber_tx_data;
  assign remote_loop_command = cur.remote_loop_command;
  assign dte_rx_data = cur.dte_rx_data;
  assign dte_cts = cur.dte_cts;
  assign dte_dsr = cur.dte_dsr;
  assign lamps = cur.lamps;

endmodule

// *** testbench/loopback_test_control_monitor.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------------------
module loopback_test_control_monitor #(
  parameter int DEBOUNCE_CYCLES = 4,
  parameter int LAMP_CHECK_CYCLES = 50,
  parameter int BLINK_CYCLES = 8
) (
  // Inputs of the block
  input wire logic sys_clk,
  input wire logic srst,
  input wire loopback_test_control_pkg::axi_req_t axi_req,
  input wire loopback_test_control_pkg::panel_in_t panel,
  input wire logic dte_rts,
  input wire logic dte_local_loop_req,
  input wire logic dte_remote_loop_req,
  input wire logic bit_tick,
  input wire logic dte_tx_data,
  input wire logic fiber_rx_data,
  input wire logic fiber_signal_valid,
  // Outputs of the block
  input wire loopback_test_control_pkg::axi_rsp_t axi_rsp,
  input wire logic fiber_tx_data,
  input wire logic remote_loop_command,
  input wire logic dte_rx_data,
  input wire logic dte_cts,
  input wire logic dte_dsr,
  input wire loopback_test_control_pkg::lamps_t lamps
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Mode flags lag the data path by a cycle, so the line loop check demands two quiet samples and the outbound check three.
  property p_reset;
    $fell(srst) |-> (dte_dsr && fiber_tx_data && !lamps.test_led && !remote_loop_command);
  endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
  property p_rts;
    $changed(dte_rts) |-> ##[1:16] (lamps.rts_led == dte_rts);
  endproperty
  a_rts: assert property (p_rts) else $error("rts lamp does not follow");
  property p_carrier;
    $changed(fiber_signal_valid) && !lamps.test_led |-> ##[1:16] (lamps.carrier_detect_led == fiber_signal_valid);
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier lamp does not follow");
  property p_tx_led;
    $stable(fiber_tx_data) [*3] |-> (lamps.transmit_activity_led == !fiber_tx_data);
  endproperty
  a_tx_led: assert property (p_tx_led) else $error("transmit lamp wrong");
  property p_line_mark;
    bit_tick && lamps.test_led && dte_dsr && !remote_loop_command ##1 lamps.test_led && dte_dsr |-> fiber_tx_data;
  endproperty
  a_line_mark: assert property (p_line_mark) else $error("line loop not sending mark");
  property p_outbound;
    bit_tick && !dte_dsr && !remote_loop_command ##1 (!dte_dsr && !remote_loop_command) [*2]
      |-> (fiber_tx_data == $past(fiber_rx_data, 2));
  endproperty
  a_outbound: assert property (p_outbound) else $error("outbound loop data wrong");
  property p_remote;
    $rose(remote_loop_command) |-> ##[0:2] (!dte_dsr && lamps.test_led);
  endproperty
  a_remote: assert property (p_remote) else $error("remote loop leads wrong");
  property p_dsr_test;
    $fell(dte_dsr) |-> ##[0:1] lamps.test_led;
  endproperty
  a_dsr_test: assert property (p_dsr_test) else $error("test lamp dark in loop");
  property p_prbs_cts;
    $rose(lamps.bit_fault_lamp) |-> ##[0:2] !dte_cts;
  endproperty
  a_prbs_cts: assert property (p_prbs_cts) else $error("cts high in pattern test");
  property p_lamp_check;
    $rose(lamps.bit_fault_lamp) && $past(dte_cts, 3) |-> lamps.bit_fault_lamp [*8];
  endproperty
  a_lamp_check: assert property (p_lamp_check) else $error("lamp check too short");
endmodule
bind loopback_test_control loopback_test_control_monitor #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
  .LAMP_CHECK_CYCLES(LAMP_CHECK_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) u_mon (.sys_clk(sys_clk), .srst(srst),
  .axi_req(axi_req), .panel(panel), .dte_rts(dte_rts), .dte_local_loop_req(dte_local_loop_req),
  .dte_remote_loop_req(dte_remote_loop_req), .bit_tick(bit_tick), .dte_tx_data(dte_tx_data),
  .fiber_rx_data(fiber_rx_data), .fiber_signal_valid(fiber_signal_valid), .axi_rsp(axi_rsp),
  .fiber_tx_data(fiber_tx_data), .remote_loop_command(remote_loop_command), .dte_rx_data(dte_rx_data),
  .dte_cts(dte_cts), .dte_dsr(dte_dsr), .lamps(lamps));

// *** testbench/far_modem_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Far modem
// ---------------------------------------------------------------------------
// Without light the receiver sees noise, so the line toggles instead of holding its last bit.
module far_modem_model (
  // Clock and bit timing
  input wire logic sys_clk,
  input wire logic bit_tick,
  // From the block
  input wire logic fiber_tx_data,
  input wire logic remote_loop_command,
  // Scenario controls
  input wire logic sig_on,
  input wire logic err_all,
  input wire logic err_some,
  // Toward the block
  output logic fiber_rx_data,
  output logic fiber_signal_valid
);
  logic [3:0] n;
  initial
  begin
    n = 4'h0;
    fiber_rx_data = 1'h1;
  end
  assign fiber_signal_valid = sig_on;
  always @(posedge sys_clk)
  begin
    if (bit_tick)
    begin
      n <= n + 4'h1;
      if (!sig_on)
        fiber_rx_data <= ~fiber_rx_data;
      else if (remote_loop_command)
        fiber_rx_data <= fiber_tx_data ^ err_all ^ (err_some && n == 4'h0);
      else
        fiber_rx_data <= n[0] ^ n[1];
    end
  end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`include "loopback_test_control_consts.svh"
// ---------------------------------------------------------------------------
// Bench
// ---------------------------------------------------------------------------
module tb;
  loopback_test_control_pkg::axi_req_t req;
  loopback_test_control_pkg::axi_rsp_t rsp;
  loopback_test_control_pkg::panel_in_t pnl;
  loopback_test_control_pkg::lamps_t lamps;
  logic sys_clk, srst, dte_rts, ll_req, rl_req, bit_tick, dte_tx_data, fiber_rx_data, sig_valid;
  logic fiber_tx_data, remote_cmd, dte_rx_data, dte_cts, dte_dsr, sig_on, err_all, err_some;
  logic [1:0] tick_cnt;
  logic [31:0] d;
  logic [1:0] r;
  logic [23:0] bits;
  int n_fail, total_checks, cycles, ones;
  loopback_test_control #(.DEBOUNCE_CYCLES(4), .LAMP_CHECK_CYCLES(50), .BLINK_CYCLES(8)) DUT (
    .sys_clk(sys_clk), .srst(srst), .axi_req(req), .axi_rsp(rsp), .panel(pnl), .dte_rts(dte_rts),
    .dte_local_loop_req(ll_req), .dte_remote_loop_req(rl_req), .bit_tick(bit_tick), .dte_tx_data(dte_tx_data),
    .fiber_rx_data(fiber_rx_data), .fiber_signal_valid(sig_valid), .fiber_tx_data(fiber_tx_data),
    .remote_loop_command(remote_cmd), .dte_rx_data(dte_rx_data), .dte_cts(dte_cts), .dte_dsr(dte_dsr),
    .lamps(lamps));
  far_modem_model u_far (.sys_clk(sys_clk), .bit_tick(bit_tick), .fiber_tx_data(fiber_tx_data),
    .remote_loop_command(remote_cmd), .sig_on(sig_on), .err_all(err_all), .err_some(err_some),
    .fiber_rx_data(fiber_rx_data), .fiber_signal_valid(sig_valid));
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic finish_test;
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (30) @(posedge sys_clk);
  endtask
  // Held well past two debounce periods so that the press is never lost.
  task automatic press(input int i);
    pnl[i] <= 1'h1;
    repeat (20) @(posedge sys_clk);
    pnl[i] <= 1'h0;
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic wait_lamp(input logic v);
    int t;
    t = 0;
    while (lamps.bit_fault_lamp !== v && t < 3000)
    begin
      @(posedge sys_clk);
      t++;
    end
    chk(lamps.bit_fault_lamp, v);
  endtask
  task automatic count_on(input int n);
    repeat (600) @(posedge sys_clk);
    ones = 0;
    repeat (n)
    begin
      @(posedge sys_clk);
      ones += lamps.bit_fault_lamp;
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw, w, b;
    aw = 1'h1;
    w = 1'h1;
    b = 1'h1;
    @(posedge sys_clk);
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'h1;
    while (b)
    begin
      @(posedge sys_clk);
      if (aw && rsp.awready)
      begin
        aw = 1'h0;
        req.awvalid <= 1'h0;
      end
      if (w && rsp.wready)
      begin
        w = 1'h0;
        req.wvalid <= 1'h0;
      end
      if (rsp.bvalid)
      begin
        b = 1'h0;
        resp = rsp.bresp;
        req.bready <= 1'h0;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ar, busy;
    ar = 1'h1;
    busy = 1'h1;
    @(posedge sys_clk);
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    while (busy)
    begin
      @(posedge sys_clk);
      if (ar && rsp.arready)
      begin
        ar = 1'h0;
        req.arvalid <= 1'h0;
      end
      if (rsp.rvalid)
      begin
        busy = 1'h0;
        v = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'h0;
      end
    end
  endtask
  // ---------------------------------------------------------------------------
  // Clock, bit strobe and watchdog
  // ---------------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    bit_tick <= (tick_cnt == 2'h3);
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial
  begin
    {srst, dte_rts, dte_tx_data, sig_on} = 4'hf;
    {req, pnl, ll_req, rl_req, err_all, err_some, tick_cnt, bit_tick} = '0;
    {cycles, n_fail, total_checks} = '0;
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    chk({dte_dsr, fiber_tx_data, lamps.test_led, remote_cmd}, 4'hc);
    axi_rd(`REG_CONTROL, d, r);
    chk({r, d}, {`RESP_OKAY, 32'h0000_0001});
    axi_rd(8'h10, d, r);
    chk(r, `RESP_SLVERR);
    axi_wr(8'h10, 32'h0000_0000, r);
    chk(r, `RESP_SLVERR);
    settle();
    chk({lamps.rts_led, dte_cts, lamps.carrier_detect_led}, 3'h7);
    dte_rts <= 1'h0;
    sig_on <= 1'h0;
    settle();
    chk({lamps.rts_led, dte_cts, lamps.carrier_detect_led}, 3'h0);
    dte_rts <= 1'h1;
    sig_on <= 1'h1;
    press(6);
    chk({dte_dsr, lamps.test_led}, 2'h1);
    press(6);
    chk({dte_dsr, lamps.test_led}, 2'h2);
    dte_tx_data <= 1'h0;
    press(5);
    chk({fiber_tx_data, dte_rx_data, lamps.receive_activity_led, lamps.transmit_activity_led}, 4'ha);
    press(5);
    chk({fiber_tx_data, lamps.transmit_activity_led, lamps.test_led}, 3'h2);
    dte_tx_data <= 1'h1;
    ll_req <= 1'h1;
    settle();
    chk(lamps.test_led, 1'h0);
    pnl.dte_local_loop_enable_jumper <= 1'h1;
    settle();
    chk({lamps.test_led, fiber_tx_data}, 2'h3);
    axi_wr(`REG_CONTROL, 32'h0000_0000, r);
    settle();
    chk(lamps.test_led, 1'h0);
    axi_wr(`REG_CONTROL, 32'h0000_0001, r);
    ll_req <= 1'h0;
    rl_req <= 1'h1;
    settle();
    chk(remote_cmd, 1'h0);
    pnl.dte_remote_loop_enable_strap <= 1'h1;
    settle();
    chk(remote_cmd, 1'h1);
    rl_req <= 1'h0;
    settle();
    press(4);
    chk({remote_cmd, dte_dsr, lamps.test_led}, 3'h5);
    pnl.carrier_forced_on_jumper <= 1'h1;
    pnl.prbs_test_button <= 1'h1;
    wait_lamp(1'h1);
    wait_lamp(1'h0);
    pnl.prbs_test_button <= 1'h0;
    for (int i = 0; i < 24; i++)
    begin
      @(posedge sys_clk iff bit_tick);
      @(posedge sys_clk);
      bits[i] = fiber_tx_data;
    end
    for (int i = 9; i < 24; i++)
      chk(bits[i], bits[i-9] ^ bits[i-5]);
    chk({dte_cts, dte_rx_data, |bits}, 3'h1);
    count_on(32);
    chk(ones, 0);
    axi_rd(`REG_STATUS, d, r);
    chk({r, d}, {`RESP_OKAY, 32'h0000_0070});
    err_all <= 1'h1;
    count_on(32);
    chk(ones, 32);
    err_all <= 1'h0;
    err_some <= 1'h1;
    count_on(48);
    chk(ones > 0 && ones < 48, 1'h1);
    axi_rd(`REG_ERRCOUNT, d, r);
    chk(d != 0, 1'h1);
    err_some <= 1'h0;
    count_on(32);
    chk(ones, 0);
    axi_wr(`REG_CONTROL, 32'h0000_0003, r);
    axi_rd(`REG_ERRCOUNT, d, r);
    chk({r, d}, {`RESP_OKAY, 32'h0000_0000});
    press(3);
    press(4);
    chk({remote_cmd, dte_dsr, dte_cts}, 3'h3);
    finish_test();
  end
endmodule
